// file: verilog/wic_ctrl.sv
// Overview of operation
// - watchdog counts only while the configuration enable bit is set
// - watchdog overflow while enabled raises a reset
// - watchdog tick is rc clock halved, then divided by a selectable prescaler
// - overflow period at 1:1 is about 17 ms
// - two low-power modes chosen by bit 4 of power control
// - low-power entry instruction enters the selected mode
// - mode 1 stops the oscillator and halts the system clock
// - mode 0 keeps the oscillator running and halts the system clock
// - pins hold level and direction while in low-power mode
// - entering low-power clears the watchdog and it keeps counting
// - entering low-power clears power-down flag and sets timeout flag
// - reset pin and watchdog overflow always wake; key and port need enables
// - timer, comparator, converter wake with own and peripheral enables; timer and converter also need conditions
// - wake ignores global enable; then no service routine is entered
// - wake delay is (value plus one) times four oscillator periods
// - in mode 0 any delay value is legal, shortest one machine cycle
// - delay register resets to all ones, 1024 oscillator periods
// - power-up timer enable bit is active low
// - brown-out enable active high, two-bit threshold select
// - three-bit oscillator select picks one of eight clock modes
// - clear instruction zeroes counter and prescaler, sets both status flags
`timescale 1ns/100ps
`default_nettype none

module wic_ctrl #(
   parameter int unsigned WDT_TICK_CYCLES = wic_pkg::WDT_TICK_CYCLES
) (
   input  wire logic                     ref_clk,
   input  wire logic                     srst,
   input  wire wic_pkg::wic_apb_req_type apb_req,
   output var  wic_pkg::wic_apb_rsp_type apb_rsp,
   input  wire logic                     watchdog_clear_instruction,
   input  wire logic                     idle_instruction,
   input  wire logic                     external_reset_pin_n,
   input  wire logic [7:0]               key_change_irq,
   input  wire logic [3:0]               port_irq,
   input  wire wic_pkg::wic_periph_type  periph,
   input  wire logic [14:0]              config_word_in,
   output logic                          system_reset,
   output logic                          watchdog_reset,
   output logic                          system_clock_halt,
   output logic                          oscillator_run,
   output logic                          io_hold,
   output logic                          core_resume,
   output logic                          isr_allowed,
   output wic_pkg::wic_osc_mode_type     oscillator_select,
   output logic                          powerup_timer_enable,
   output logic                          brownout_enable,
   output logic [1:0]                    brownout_threshold_select
);
   import wic_pkg::*;

   // pin synchronisers: bit 12 reset pin, 11:8 port, 7:0 key
   logic [12:0]   pin_s1_reg;
   logic [12:0]   pin_s2_reg;
   logic [12:0]   pin_s3_reg;
   logic [12:0]   pin_reg;
   logic [12:0]   pin_next;
   logic [12:0]   pin_agree;

   logic [CFG_WIDTH-1:0] cfg_reg;
   logic [7:0]    wake_delay_reg;
   logic          low_power_mode_select_reg;
   logic [16:0]   wake_en_reg;
   logic [2:0]    presc_sel_reg;
   logic          warn_reg;
   logic          to_n_reg;
   logic          pd_n_reg;
   logic          mode_reg;

   logic [12:0]   rc_cnt_reg;
   logic [6:0]    presc_reg;
   logic [8:0]    wdt_cnt_reg;
   logic [9:0]    delay_cnt_reg;
   wic_state_type state_reg;
   wic_state_type state_next;

   logic          sys_reset_reg;
   logic          wdt_reset_reg;
   logic          halt_reg;
   logic          osc_run_reg;
   logic          io_hold_reg;
   logic          resume_reg;
   logic          isr_ok_reg;
   logic [31:0]   prdata_reg;
   logic          pready_reg;
   logic          pslverr_reg;

   // watchdog timing
   logic          wdt_en;
   logic          rc_tick;
   logic [6:0]    presc_lim;
   logic          presc_done;
   logic          wdt_ovf;
   logic          clr_go;
   logic          idle_go;
   logic          ext_reset_fall;
   logic          sys_reset_go;
   logic          wdt_zero;

   // wake sources
   logic          periph_en;
   logic          key_wake;
   logic          port_wake;
   logic          timer_wake;
   logic          cmp_wake;
   logic          adc_wake;
   logic          wake_any;
   logic          wake_start;
   logic          mode_eff;

   // bus decode
   logic          acc;
   logic          do_wr;
   logic          rd_phase;
   logic [17:0]   idx;
   logic          aligned;
   logic          hit_pwr;
   logic          hit_dly;
   logic          hit_cfg;
   logic          hit_wen;
   logic          hit_wdc;
   logic          hit_sts;
   logic          mapped;
   logic [31:0]   rd_data;
   logic [31:0]   pwr_word;
   logic [31:0]   sts_word;

   // a change counts only once the second and third stages agree
   assign pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
   assign pin_next  = (pin_s2_reg & pin_agree) | (pin_reg & ~pin_agree);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pin_s1_reg <= PIN_SYNC_RST;
         pin_s2_reg <= PIN_SYNC_RST;
         pin_s3_reg <= PIN_SYNC_RST;
         pin_reg    <= PIN_SYNC_RST;
      end else begin
         pin_s1_reg <= {external_reset_pin_n, port_irq, key_change_irq};
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         pin_reg    <= pin_next;
      end
   end

   assign ext_reset_fall = pin_reg[12] & ~pin_next[12];

   // strap-like configuration word is caught while reset is held
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cfg_reg <= config_word_in;
      end
   end

   assign wdt_en        = cfg_reg[CFG_WDT_EN_BIT];
   assign oscillator_select         = wic_osc_mode_type'(cfg_reg[CFG_OSC_LSB +: 3]);
   assign powerup_timer_enable      = ~cfg_reg[CFG_PWRT_N_BIT];
   assign brownout_enable           = cfg_reg[CFG_BOR_EN_BIT];
   assign brownout_threshold_select = cfg_reg[CFG_BOR_SEL_LSB +: 2];

   // rc clock is modelled as a free-running divider of ref_clk
   assign rc_tick    = rc_cnt_reg == 13'(WDT_TICK_CYCLES - 1);
   assign presc_lim  = (7'h01 << presc_sel_reg) - 7'h01;
   assign presc_done = rc_tick & (presc_reg == presc_lim);
   assign wdt_ovf    = wdt_en & presc_done & (wdt_cnt_reg == 9'(WDT_OVF_TICKS - 1));

   // a reset event in the same cycle wins, so the core is never parked in idle by it
   assign clr_go       = watchdog_clear_instruction & ~sys_reset_go & (state_reg == ST_RUN);
   assign idle_go      = idle_instruction & ~watchdog_clear_instruction & ~sys_reset_go
                         & (state_reg == ST_RUN);
   assign sys_reset_go = ext_reset_fall | wdt_ovf;
   assign wdt_zero     = clr_go | idle_go | sys_reset_go;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rc_cnt_reg <= 13'h0000;
      end else begin
         rc_cnt_reg <= rc_tick ? 13'h0000 : rc_cnt_reg + 13'h0001;
      end
   end

   // a disabled watchdog simply freezes; clear still zeroes it
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         presc_reg   <= 7'h00;
         wdt_cnt_reg <= 9'h000;
      end else if (wdt_zero) begin
         presc_reg   <= 7'h00;
         wdt_cnt_reg <= 9'h000;
      end else if (wdt_en & rc_tick) begin
         presc_reg <= presc_done ? 7'h00 : presc_reg + 7'h01;
         if (presc_done) begin
            wdt_cnt_reg <= wdt_cnt_reg + 9'h001;
         end
      end
   end

   // status flags, reset value of both is one
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         to_n_reg <= 1'h1;
         pd_n_reg <= 1'h1;
      end else if (wdt_ovf) begin
         to_n_reg <= 1'h0;
      end else if (clr_go) begin
         to_n_reg <= 1'h1;
         pd_n_reg <= 1'h1;
      end else if (idle_go) begin
         to_n_reg <= 1'h1;
         pd_n_reg <= 1'h0;
      end
   end

   // wake qualification; global enable plays no part here
   assign periph_en  = wake_en_reg[WEN_PERIPH_BIT];
   assign key_wake   = |(pin_reg[7:0] & wake_en_reg[WEN_KEY_LSB +: 8]);
   assign port_wake  = |(pin_reg[11:8] & wake_en_reg[WEN_PORT_LSB +: 4]);
   assign timer_wake = periph.gated_timer_irq & periph.gated_timer_async
                       & wake_en_reg[WEN_TIMER_BIT] & periph_en;
   assign cmp_wake   = periph.comparator_irq & wake_en_reg[WEN_CMP_BIT] & periph_en;
   assign adc_wake   = periph.converter_irq & periph.converter_rc_clock
                       & wake_en_reg[WEN_ADC_BIT] & periph_en;
   assign wake_any   = key_wake | port_wake | timer_wake | cmp_wake | adc_wake;
   assign wake_start = (state_reg == ST_IDLE) & wake_any & ~sys_reset_go;
   assign mode_eff   = idle_go ? low_power_mode_select_reg : mode_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_RUN: begin
            if (idle_go) begin
               state_next = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (sys_reset_go) begin
               state_next = ST_RUN;
            end else if (wake_any) begin
               state_next = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (sys_reset_go || delay_cnt_reg == 10'h000) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_reg     <= ST_RUN;
         mode_reg      <= 1'h0;
         delay_cnt_reg <= 10'h000;
      end else begin
         state_reg <= state_next;
         if (idle_go) begin
            mode_reg <= low_power_mode_select_reg;
         end
         if (wake_start) begin
            delay_cnt_reg <= {wake_delay_reg, 2'h3};
         end else if (state_reg == ST_WAKE && delay_cnt_reg != 10'h000) begin
            delay_cnt_reg <= delay_cnt_reg - 10'h001;
         end
      end
   end

   // core-facing outputs, all registered; halt, oscillator and hold from the next state, resets from this cycle's events
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         halt_reg      <= 1'h0;
         osc_run_reg   <= 1'h1;
         io_hold_reg   <= 1'h0;
         resume_reg    <= 1'h0;
         sys_reset_reg <= 1'h0;
         wdt_reset_reg <= 1'h0;
         isr_ok_reg    <= 1'h0;
      end else begin
         halt_reg      <= state_next != ST_RUN;
         osc_run_reg   <= ~(state_next == ST_IDLE && mode_eff);
         io_hold_reg   <= state_next != ST_RUN;
         resume_reg    <= (state_reg == ST_WAKE) & (state_next == ST_RUN) & ~sys_reset_go;
         sys_reset_reg <= sys_reset_go;
         wdt_reset_reg <= wdt_ovf;
         if (idle_go) begin
            isr_ok_reg <= 1'h0;
         end else if (wake_start) begin
            isr_ok_reg <= wake_en_reg[WEN_GLOBAL_BIT];
         end
      end
   end

   assign system_reset      = sys_reset_reg;
   assign watchdog_reset    = wdt_reset_reg;
   assign system_clock_halt = halt_reg;
   assign oscillator_run    = osc_run_reg;
   assign io_hold           = io_hold_reg;
   assign core_resume       = resume_reg;
   assign isr_allowed       = isr_ok_reg;

   // apb slave: one wait state, write lands when pready is sampled high
   assign acc      = apb_req.psel & apb_req.penable;
   assign rd_phase = acc & ~pready_reg;
   assign do_wr    = acc & pready_reg & apb_req.pwrite;
   assign idx      = apb_req.paddr[19:2];
   assign aligned  = apb_req.paddr[1:0] == 2'h0;
   assign hit_pwr  = aligned & (idx == IDX_POWER_CONTROL);
   assign hit_dly  = aligned & (idx == IDX_WAKE_DELAY);
   assign hit_cfg  = aligned & (idx == IDX_CONFIG_WORD);
   assign hit_wen  = aligned & (idx == IDX_WAKE_ENABLE);
   assign hit_wdc  = aligned & (idx == IDX_WDT_CONTROL);
   assign hit_sts  = aligned & (idx == IDX_STATUS);
   assign mapped   = hit_pwr | hit_dly | hit_cfg | hit_wen | hit_wdc | hit_sts;

   assign pwr_word = {27'h0000000, low_power_mode_select_reg, to_n_reg, pd_n_reg, 2'h0};
   assign sts_word = {13'h0000, warn_reg, state_reg, 7'h00, wdt_cnt_reg};
   assign rd_data  = hit_pwr ? pwr_word :
                     hit_dly ? {24'h000000, wake_delay_reg} :
                     hit_cfg ? {17'h00000, cfg_reg} :
                     hit_wen ? {15'h0000, wake_en_reg} :
                     hit_wdc ? {29'h00000000, presc_sel_reg} :
                     hit_sts ? sts_word : 32'h00000000;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pready_reg  <= 1'h0;
         pslverr_reg <= 1'h0;
         prdata_reg  <= 32'h00000000;
      end else begin
         pready_reg  <= rd_phase;
         pslverr_reg <= rd_phase & ~mapped;
         prdata_reg  <= (rd_phase & ~apb_req.pwrite) ? rd_data : 32'h00000000;
      end
   end

   assign apb_rsp = '{prdata: prdata_reg, pready: pready_reg, pslverr: pslverr_reg};

   // warning: idle 1 entered with a delay too short for oscillator restart
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wake_delay_reg <= WAKE_DELAY_RST;
         low_power_mode_select_reg       <= LOW_POWER_MODE_SELECT_RST;
         wake_en_reg    <= WAKE_EN_RST;
         presc_sel_reg  <= PRESC_SEL_RST;
         warn_reg       <= 1'h0;
      end else begin
         if (do_wr & hit_dly) begin
            wake_delay_reg <= apb_req.pwdata[7:0];
         end
         if (do_wr & hit_pwr) begin
            low_power_mode_select_reg <= apb_req.pwdata[PWR_LOW_POWER_MODE_SELECT_BIT];
         end
         if (do_wr & hit_wen) begin
            wake_en_reg <= apb_req.pwdata[16:0];
         end
         if (do_wr & hit_wdc) begin
            presc_sel_reg <= apb_req.pwdata[2:0];
         end
         if (idle_go & low_power_mode_select_reg & (wake_delay_reg < IDLE1_MIN_DELAY)) begin
            warn_reg <= 1'h1;
         end else if (do_wr & hit_sts & apb_req.pwdata[STS_WARN_BIT]) begin
            warn_reg <= 1'h0;
         end
      end
   end

   // checks
   logic [10:0] wake_len_reg;
   logic [7:0]  dly_at_wake_reg;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wake_len_reg    <= 11'h000;
         dly_at_wake_reg <= 8'h00;
      end else begin
         if (wake_start) begin
            wake_len_reg    <= 11'h000;
            dly_at_wake_reg <= wake_delay_reg;
         end else if (state_reg == ST_WAKE) begin
            wake_len_reg <= wake_len_reg + 11'h001;
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   a_wdt_disabled_hold: assert property (
      (!wdt_en && !wdt_zero) |=> $stable(wdt_cnt_reg) && $stable(presc_reg))
      else $error("watchdog moved while disabled");
   a_wdt_ovf_reset: assert property (
      (wdt_en && presc_done && wdt_cnt_reg == 9'(WDT_OVF_TICKS - 1))
      |=> system_reset && watchdog_reset && !to_n_reg)
      else $error("overflow gave no reset");
   a_clear_effect: assert property (
      clr_go |=> wdt_cnt_reg == 9'h000 && presc_reg == 7'h00 && to_n_reg && pd_n_reg)
      else $error("clear instruction effect wrong");
   a_idle_entry_flags: assert property (
      idle_go |=> state_reg == ST_IDLE && !pd_n_reg && to_n_reg
                  && wdt_cnt_reg == 9'h000 && system_clock_halt)
      else $error("idle entry flags wrong");
   a_idle1_osc_stop: assert property (
      (state_reg == ST_IDLE && mode_reg) |-> !oscillator_run && system_clock_halt)
      else $error("oscillator running in idle 1");
   a_idle0_osc_run: assert property (
      (state_reg == ST_IDLE && !mode_reg) |-> oscillator_run && system_clock_halt)
      else $error("oscillator stopped in idle 0");
   a_io_hold_idle: assert property (
      (state_reg != ST_RUN) |-> io_hold)
      else $error("pins not held in low power");
   a_wake_load: assert property (
      wake_start |=> state_reg == ST_WAKE
                     && delay_cnt_reg == {$past(wake_delay_reg), 2'h3})
      else $error("wake delay load wrong");
   a_wake_length: assert property (
      core_resume |-> wake_len_reg == 11'({dly_at_wake_reg, 2'h0}) + 11'h004)
      else $error("wake delay length wrong");
   a_wake_no_isr: assert property (
      (wake_start && !wake_en_reg[WEN_GLOBAL_BIT]) |=> !isr_allowed)
      else $error("service allowed with global enable clear");
   a_reset_exits: assert property (
      (state_reg != ST_RUN && sys_reset_go) |=> state_reg == ST_RUN && system_reset)
      else $error("reset did not leave low power");

   c_idle0_wake: cover property (idle_go && !low_power_mode_select_reg ##[1:1000] core_resume);
   c_idle1_wake: cover property (idle_go && low_power_mode_select_reg ##[1:1000] core_resume);
   c_wdt_overflow: cover property (wdt_ovf);
   c_reset_in_idle: cover property (state_reg == ST_IDLE && ext_reset_fall);

endmodule

`default_nettype wire

// file: pkg/wic_pkg.sv
package wic_pkg;

   // register indices; byte address is four times the index
   localparam logic [17:0] IDX_POWER_CONTROL = 18'h0008E;
   localparam logic [17:0] IDX_WAKE_DELAY    = 18'h0009B;
   localparam logic [17:0] IDX_CONFIG_WORD   = 18'h08001;
   localparam logic [17:0] IDX_WAKE_ENABLE   = 18'h000C0;
   localparam logic [17:0] IDX_WDT_CONTROL   = 18'h000C1;
   localparam logic [17:0] IDX_STATUS        = 18'h000C2;

   // power control fields
   localparam int unsigned PWR_LOW_POWER_MODE_SELECT_BIT  = 4;
   localparam int unsigned PWR_TO_N_BIT  = 3;
   localparam int unsigned PWR_PD_N_BIT  = 2;

   // configuration word fields
   localparam int unsigned CFG_WIDTH       = 15;
   localparam int unsigned CFG_OSC_LSB     = 0;
   localparam int unsigned CFG_WDT_EN_BIT  = 3;
   localparam int unsigned CFG_PWRT_N_BIT  = 4;
   localparam int unsigned CFG_BOR_EN_BIT  = 5;
   localparam int unsigned CFG_BOR_SEL_LSB = 7;

   // wake enable fields
   localparam int unsigned WEN_KEY_LSB    = 0;
   localparam int unsigned WEN_PORT_LSB   = 8;
   localparam int unsigned WEN_TIMER_BIT  = 12;
   localparam int unsigned WEN_CMP_BIT    = 13;
   localparam int unsigned WEN_ADC_BIT    = 14;
   localparam int unsigned WEN_PERIPH_BIT = 15;
   localparam int unsigned WEN_GLOBAL_BIT = 16;

   // status fields
   localparam int unsigned STS_STATE_LSB  = 16;
   localparam int unsigned STS_WARN_BIT   = 18;

   // reset values
   localparam logic [7:0]  WAKE_DELAY_RST = 8'hFF;
   localparam logic        LOW_POWER_MODE_SELECT_RST       = 1'h0;
   localparam logic [16:0] WAKE_EN_RST    = 17'h00000;
   localparam logic [2:0]  PRESC_SEL_RST  = 3'h0;
   localparam logic [12:0] PIN_SYNC_RST   = 13'h1000;
   localparam logic [7:0]  IDLE1_MIN_DELAY = 8'h0F;

   // timing: watchdog rc clock halved, overflow at 1:1 prescale
   localparam int unsigned REF_CLK_HZ      = 100_000_000;
   localparam int unsigned WDT_RC_HZ       = 32_000;
   localparam int unsigned WDT_RC_DIV      = 2;
   localparam int unsigned WDT_TICK_CYCLES = REF_CLK_HZ / (WDT_RC_HZ / WDT_RC_DIV);
   localparam int unsigned WDT_TICK_NS     = 1_000_000_000 / (WDT_RC_HZ / WDT_RC_DIV);
   localparam int unsigned WDT_OVF_TIME_NS = 17_000_000;
   localparam int unsigned WDT_OVF_TICKS   = WDT_OVF_TIME_NS / WDT_TICK_NS;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [19:0] paddr;
      logic [31:0] pwdata;
   } wic_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } wic_apb_rsp_type;

   typedef struct packed {
      logic gated_timer_irq;
      logic gated_timer_async;
      logic comparator_irq;
      logic converter_irq;
      logic converter_rc_clock;
   } wic_periph_type;

   typedef enum logic [2:0] {
      OSC_LOW_POWER_XTAL  = 3'h0,
      OSC_RC_CLKOUT       = 3'h1,
      OSC_HIGH_SPEED_XTAL = 3'h2,
      OSC_EXTERNAL_CLOCK  = 3'h3,
      OSC_INTERNAL_CLKOUT = 3'h4,
      OSC_INTERNAL_IO     = 3'h5,
      OSC_RC_IO           = 3'h6,
      OSC_STD_XTAL        = 3'h7
   } wic_osc_mode_type;

   typedef enum logic [1:0] {
      ST_RUN  = 2'h0,
      ST_IDLE = 2'h1,
      ST_WAKE = 2'h3
   } wic_state_type;

endpackage

// file: verif/wic_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module wic_core_model (
   input  wire logic       ref_clk,
   input  wire logic [7:0] key_cmd,
   input  wire logic       rst_cmd,
   output logic [7:0]      key_change_irq = 8'h00,
   output logic [3:0]      port_irq = 4'h0,
   output logic            external_reset_pin_n = 1'b1
);
   // requests are levels held until the bench drops them; the reset pin rests high unless commanded
   always @(posedge ref_clk) begin
      key_change_irq <= key_cmd;
      port_irq <= key_cmd[3:0];
      external_reset_pin_n <= ~rst_cmd;
   end
endmodule
`default_nettype wire

// file: verif/test_watchdog_idle_wakeup_control.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
   $display("ERROR %0t got %0h exp %0h", $time, a, b); end end
module test_watchdog_idle_wakeup_control;
   import wic_pkg::*;
   logic ref_clk = 0, srst = 1, watchdog_clear_instruction = 0, idle_instruction = 0;
   logic rst_cmd = 0;
   logic [7:0] key_cmd = 0, d;
   logic [14:0] config_word_in = 0;
   wic_apb_req_type apb_req = '0;
   wic_apb_rsp_type apb_rsp;
   wic_periph_type periph = '0;
   wic_osc_mode_type oscillator_select;
   logic [7:0] key_change_irq;
   logic [3:0] port_irq;
   logic [1:0] brownout_threshold_select;
   logic external_reset_pin_n, system_reset, watchdog_reset, system_clock_halt, oscillator_run;
   logic io_hold, core_resume, isr_allowed, powerup_timer_enable, brownout_enable, err;
   logic [31:0] rd, c;
   int miscompares = 0, tests_run = 0, n;
   // a short tick keeps the watchdog overflow near a thousand cycles
   wic_ctrl #(.WDT_TICK_CYCLES(4)) uut (.*);
   wic_core_model partner (.*);
   always #5 ref_clk = ~ref_clk;
   function automatic int wake_cycles(input logic [7:0] v);
      return 4 * (v + 1);
   endfunction
   task automatic close_out(input bit hung);
      if (hung) miscompares++;
      $display("compared %0d, mismatched %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
   endtask
   task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] v);
      int k;
      k = 0;
      apb_req <= '{1'b1, 1'b0, w, a, v};
      tick(1);
      apb_req.penable <= 1'b1;
      do begin tick(1); k++; end while (apb_rsp.pready !== 1'b1 && k < 20);
      if (k >= 20) close_out(1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
      tick(1);
   endtask
   task automatic restart(input logic [14:0] cw);
      config_word_in <= cw;
      srst <= 1;
      tick(4);
      srst <= 0;
      tick(1);
   endtask
   task automatic wait_wdt(input int lim);
      n = 0;
      while (watchdog_reset !== 1'b1 && n < lim) begin tick(1); n++; end
   endtask
   task automatic idle_wake(input logic m, input logic [3:0] s);
      logic [4:0] pw;
      // mode 1 needs a settling delay of at least 0x0F
      d = m ? 8'h0F + 8'($urandom_range(0, 64)) : 8'($urandom_range(0, 255));
      // 12..14 pick timer, comparator, converter; the early pattern lacks the timer or converter qualifier, or the comparator request
      pw = (s == 4'hC) ? 5'h18 : (s == 4'hD) ? 5'h04 : (s == 4'hE) ? 5'h03 : 5'h00;
      apb(1, 20'h26C, {24'h0, d});
      apb(1, 20'h238, {27'h0, m, 4'h0});
      apb(1, 20'h300, (32'h1 << s) | {15'h0, d[0], s >= 4'hC, 15'h0});
      key_cmd <= ~(8'h01 << s[2:0]);
      periph <= pw & 5'h12;
      idle_instruction <= 1;
      tick(1);
      idle_instruction <= 0;
      tick(10);
      `CHK({system_clock_halt, io_hold}, 2'h3);
      `CHK(oscillator_run, ~m);
      apb(0, 20'h238, 0);
      `CHK(rd[4:2], {m, 2'h2});
      key_cmd <= 8'h01 << s[2:0];
      periph <= pw;
      n = 0;
      while (core_resume !== 1'b1 && n < 1200) begin tick(1); n++; end
      `CHK(n > wake_cycles(d) && n <= wake_cycles(d) + 10, 1'b1);
      `CHK(isr_allowed, d[0]);
      key_cmd <= 0;
      periph <= '0;
   endtask
   initial begin
      n = $urandom(55);
      for (int i = 0; i < 8; i++) begin
         c = $urandom;
         restart({c[14:4], 1'b0, i[2:0]});
         `CHK(oscillator_select, i[2:0]);
         `CHK(powerup_timer_enable, ~c[4]);
         `CHK({brownout_enable, brownout_threshold_select}, {c[5], c[8:7]});
         apb(0, 20'h26C, 0);
         `CHK(rd, 32'h000000FF);
         apb(0, 20'h3FC, 0);
         `CHK(err, 1'b1);
         idle_wake(i[0], (i < 3) ? 4'(12 + i) : 4'($urandom_range(0, 11)));
         $display("config and wake test %0d done", i);
      end
      restart(15'h0008);
      wait_wdt(800);
      `CHK(n, 800);
      watchdog_clear_instruction <= 1;
      tick(1);
      watchdog_clear_instruction <= 0;
      wait_wdt(1300);
      `CHK(n >= 1080 && n <= 1096, 1'b1);
      `CHK(system_reset, 1'b1);
      restart(15'h0000);
      wait_wdt(1300);
      `CHK(n, 1300);
      restart(15'h0008);
      apb(1, 20'h304, 32'h1);
      wait_wdt(2300);
      `CHK(n >= 2160 && n <= 2176, 1'b1);
      $display("watchdog test done");
      restart(15'h0000);
      idle_instruction <= 1;
      tick(1);
      idle_instruction <= 0;
      tick(4);
      `CHK(system_clock_halt, 1'b1);
      rst_cmd <= 1;
      n = 0;
      while (system_reset !== 1'b1 && n < 20) begin tick(1); n++; end
      `CHK({n < 20, system_clock_halt, io_hold, oscillator_run}, 4'h9);
      rst_cmd <= 0;
      tick(8);
      `CHK({system_reset, system_clock_halt}, 2'h0);
      $display("reset pin test done");
      close_out(0);
   end
endmodule
`default_nettype wire
